//--- design/phy_status_and_ident_regs.sv
// status and identifier registers of the physical layer, read over the management port
// assumes condition inputs are asynchronous and the read strobe is on ref_clk
`include "phy_status_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module phy_status_and_ident_regs
  import phy_status_pkg::*;
#(
  // arbitrary neutral identity values
  parameter logic [23:0] ORG_IDENT = 24'h0a1b2c,
  parameter logic [5:0] MODEL_NUM = 6'h01,
  parameter logic [3:0] MODEL_REV = 4'h0,
  parameter logic IDENT_ZERO = 1'b0
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire phy_events_type ev_in,
  input wire logic rd_stb,
  input wire logic [7:0] rd_addr,
  output logic [15:0] rd_data,
  output logic rd_valid
);

  state_type s_reg;
  state_type s_next;

  logic [15:0] org_ident_upper_bits;
  logic [15:0] ident_low;
  logic [15:0] phy_basic_status;
  logic stat_rd;

  // ---------------------------------------------------------------
  // decoding helpers
  // ---------------------------------------------------------------
  // address match, shared by the status read decode and the checks
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // status word built from the registered state only
  function automatic logic [15:0] status_word(input state_type st);
    logic [15:0] w;
    w = `RD_DATA_RESET;
    // capability bits above the reserved field stay zero here
    w[`ST_CAP_HI:`ST_CAP_LO] = '0;
    w[`ST_RSVD_HI:`ST_RSVD_LO] = '0;
    w[`ST_PRE_SUPP] = 1'b1;
    w[`ST_ANEG_DONE] = st.filt.aneg_done;
    w[`ST_REM_FAULT] = st.rem_fault;
    w[`ST_ANEG_ABLE] = 1'b1;
    w[`ST_LINK] = st.link;
    w[`ST_JABBER] = st.jabber;
    w[`ST_EXT_CAP] = 1'b1;
    return w;
  endfunction

  assign org_ident_upper_bits = IDENT_ZERO ? `RD_DATA_RESET : ORG_IDENT[`ID_HIGH_MSB:`ID_HIGH_LSB];
  assign ident_low = IDENT_ZERO ? `RD_DATA_RESET : {ORG_IDENT[`ID_LOW_MSB:0], MODEL_NUM, MODEL_REV};
  assign stat_rd = rd_stb && addr_hit(rd_addr, `OFS_BASIC_STATUS);

  // ---------------------------------------------------------------
  // status word assembly
  // ---------------------------------------------------------------
  assign phy_basic_status = status_word(s_reg);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.s1 = ev_in;
    s_next.s2 = s_reg.s1;
    s_next.s3 = s_reg.s2;
    // a change counts once the last two stages agree
    for (int i = 0; i < $bits(phy_events_type); i++) begin
      if (s_reg.s2[i] == s_reg.s3[i]) begin
        s_next.filt[i] = s_reg.s3[i];
      end
    end
    // clear on read first, so an event in the same cycle wins
    if (stat_rd) begin
      s_next.rem_fault = 1'b0;
      s_next.jabber = 1'b0;
      s_next.link = s_reg.filt.link_good;
    end
    if (s_reg.filt.far_fault || s_reg.filt.lp_fault) begin
      s_next.rem_fault = 1'b1;
    end
    if (s_reg.filt.jabber && s_reg.filt.speed_10) begin
      s_next.jabber = 1'b1;
    end
    if (!s_reg.filt.link_good) begin
      s_next.link = 1'b0;
    end
    s_next.rd_valid = rd_stb;
    if (rd_stb) begin
      unique case (rd_addr)
        `OFS_BASIC_STATUS: s_next.rd_data = phy_basic_status;
        `OFS_IDENT_HIGH: s_next.rd_data = org_ident_upper_bits;
        `OFS_IDENT_LOW: s_next.rd_data = ident_low;
        default: s_next.rd_data = `RD_DATA_RESET;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rd_data = s_reg.rd_data;
  assign rd_valid = s_reg.rd_valid;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  valid_pulse_a: assert property (
    rd_stb
    |=> rd_valid)
    else $error("read answer missing");
  valid_idle_a: assert property (
    !rd_stb
    |=> !rd_valid)
    else $error("read answer without strobe");
  data_hold_a: assert property (
    !rd_stb
    |=> $stable(rd_data))
    else $error("read data moved without strobe");
  unmapped_zero_a: assert property (
    rd_stb && !stat_rd && !addr_hit(rd_addr, `OFS_IDENT_HIGH) && !addr_hit(rd_addr, `OFS_IDENT_LOW)
    |=> rd_data == `RD_DATA_RESET)
    else $error("unmapped read not zero");

  // ---------------------------------------------------------------
  // constant, reserved and negotiation complete status bits
  // ---------------------------------------------------------------
  rsvd_zero_a: assert property (
    stat_rd
    |=> rd_valid && rd_data[`ST_RSVD_HI:`ST_RSVD_LO] == '0)
    else $error("reserved status bits not zero");
  upper_zero_a: assert property (
    stat_rd
    |=> rd_data[`ST_CAP_HI:`ST_CAP_LO] == '0)
    else $error("upper status bits not zero");
  const_ones_a: assert property (
    stat_rd
    |=> rd_data[`ST_PRE_SUPP] && rd_data[`ST_ANEG_ABLE] && rd_data[`ST_EXT_CAP])
    else $error("constant status bits not one");
  aneg_done_a: assert property (
    stat_rd
    |=> rd_data[`ST_ANEG_DONE] == $past(s_reg.filt.aneg_done))
    else $error("negotiation complete bit mismatch");

  // ---------------------------------------------------------------
  // remote fault latch
  // ---------------------------------------------------------------
  fault_latch_a: assert property (
    s_reg.filt.lp_fault
    |=> s_reg.rem_fault)
    else $error("remote fault not latched");
  fault_far_a: assert property (
    s_reg.filt.far_fault
    |=> s_reg.rem_fault)
    else $error("far-end fault not latched");
  fault_hold_a: assert property (
    s_reg.rem_fault && !stat_rd
    |=> s_reg.rem_fault)
    else $error("remote fault lost without read");
  fault_clear_a: assert property (
    stat_rd && !s_reg.filt.far_fault && !s_reg.filt.lp_fault
    |=> !s_reg.rem_fault)
    else $error("remote fault not cleared by read");
  fault_bit_a: assert property (
    stat_rd
    |=> rd_data[`ST_REM_FAULT] == $past(s_reg.rem_fault))
    else $error("remote fault bit not returned");

  // ---------------------------------------------------------------
  // jabber latch
  // ---------------------------------------------------------------
  jabber_latch_a: assert property (
    s_reg.filt.jabber && s_reg.filt.speed_10
    |=> s_reg.jabber)
    else $error("jabber not latched");
  jabber_gate_a: assert property (
    $rose(s_reg.jabber)
    |-> $past(s_reg.filt.jabber && s_reg.filt.speed_10))
    else $error("jabber latched outside 10 Mb/s");
  jabber_hold_a: assert property (
    s_reg.jabber && !stat_rd
    |=> s_reg.jabber)
    else $error("jabber lost without read");
  jabber_clear_a: assert property (
    stat_rd && !(s_reg.filt.jabber && s_reg.filt.speed_10)
    |=> !s_reg.jabber)
    else $error("jabber not cleared by read");
  read_return_a: assert property (
    stat_rd && s_reg.jabber
    |=> rd_data[`ST_JABBER] && rd_valid)
    else $error("clearing read lost latched value");

  // ---------------------------------------------------------------
  // link status
  // ---------------------------------------------------------------
  link_fail_a: assert property (
    !s_reg.filt.link_good
    |=> !s_reg.link)
    else $error("link bit survived failure");
  link_set_a: assert property (
    $rose(s_reg.link)
    |-> $past(stat_rd) && $past(s_reg.filt.link_good))
    else $error("link bit set without read");
  link_hold_a: assert property (
    !s_reg.link && !stat_rd
    |=> !s_reg.link)
    else $error("link bit rose without read");
  link_read_a: assert property (
    stat_rd && s_reg.filt.link_good
    |=> s_reg.link)
    else $error("link bit not reloaded by read");
  link_bit_a: assert property (
    stat_rd
    |=> rd_data[`ST_LINK] == $past(s_reg.link))
    else $error("link bit not returned");

  // ---------------------------------------------------------------
  // identifier words
  // ---------------------------------------------------------------
  ident_high_a: assert property (
    rd_stb && addr_hit(rd_addr, `OFS_IDENT_HIGH)
    |=> rd_data == org_ident_upper_bits)
    else $error("identifier high mismatch");
  ident_low_a: assert property (
    rd_stb && addr_hit(rd_addr, `OFS_IDENT_LOW)
    |=> rd_data[15:10] == ORG_IDENT[`ID_LOW_MSB:0] || IDENT_ZERO)
    else $error("identifier low mismatch");
  ident_zero_a: assert property (
    IDENT_ZERO && rd_stb && (addr_hit(rd_addr, `OFS_IDENT_HIGH) || addr_hit(rd_addr, `OFS_IDENT_LOW))
    |=> rd_data == `RD_DATA_RESET)
    else $error("zero identifier not zero");

  // ---------------------------------------------------------------
  // input synchroniser
  // ---------------------------------------------------------------
  sync_shift_a: assert property (
    1'b1
    |=> s_reg.s3 == $past(s_reg.s2) && s_reg.s2 == $past(s_reg.s1))
    else $error("synchroniser stages did not shift");
  filter_take_a: assert property (
    s_reg.s2 == s_reg.s3
    |=> s_reg.filt == $past(s_reg.s3))
    else $error("filter missed agreed value");
  filter_hold_a: assert property (
    s_reg.s2 != s_reg.s3
    |=> $stable(s_reg.filt))
    else $error("filter moved on disagreement");

  // ---------------------------------------------------------------
  // main scenarios
  // ---------------------------------------------------------------
  fault_read_c: cover property (s_reg.rem_fault ##1 stat_rd ##1 !s_reg.rem_fault);
  link_recover_c: cover property (!s_reg.link && s_reg.filt.link_good ##1 stat_rd ##1 s_reg.link);
  jabber_c: cover property ($rose(s_reg.jabber));
  ident_pair_c: cover property (rd_stb && addr_hit(rd_addr, `OFS_IDENT_HIGH)
    ##2 rd_stb && addr_hit(rd_addr, `OFS_IDENT_LOW));

endmodule

`default_nettype wire

//--- design/phy_status_pkg.sv
// types shared by the status and identifier bank
// no assumptions beyond the register header
package phy_status_pkg;

  // raw condition inputs from the line side of the physical layer
  typedef struct packed {
    logic speed_10;
    logic jabber;
    logic lp_fault;
    logic far_fault;
    logic aneg_done;
    logic link_good;
  } phy_events_type;

  typedef struct packed {
    phy_events_type s1;
    phy_events_type s2;
    phy_events_type s3;
    phy_events_type filt;
    logic rem_fault;
    logic link;
    logic jabber;
    logic [15:0] rd_data;
    logic rd_valid;
  } state_type;

endpackage

//--- design/phy_status_regs.svh
// register offsets, field positions and reset values of the status and identifier bank
// assumes a byte-addressed management read port of 8 address bits
`ifndef PHY_STATUS_REGS_SVH
`define PHY_STATUS_REGS_SVH

`define OFS_BASIC_STATUS 8'h84
`define OFS_IDENT_HIGH 8'h88
`define OFS_IDENT_LOW 8'h8c

`define ST_CAP_HI 15
`define ST_CAP_LO 11
`define ST_RSVD_HI 10
`define ST_RSVD_LO 7
`define ST_PRE_SUPP 6
`define ST_ANEG_DONE 5
`define ST_REM_FAULT 4
`define ST_ANEG_ABLE 3
`define ST_LINK 2
`define ST_JABBER 1
`define ST_EXT_CAP 0

`define ID_HIGH_MSB 21
`define ID_HIGH_LSB 6
`define ID_LOW_MSB 5

`define RD_DATA_RESET 16'h0000
`define SYNC_STAGES 3

`endif

//--- test/mgmt_master_model.sv
// management read master model
// assumes the answer comes one cycle after the strobe edge
`timescale 1ns/1ns
`default_nettype none
module mgmt_master_model (
  input wire logic ref_clk,
  input wire logic rd_valid,
  input wire logic [15:0] rd_data,
  output logic rd_stb,
  output logic [7:0] rd_addr
);
  initial begin
    rd_stb = 1'b0;
    rd_addr = 8'h00;
  end
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    int n;
    n = 0;
    @(negedge ref_clk);
    rd_stb = 1'b1;
    rd_addr = a;
    @(negedge ref_clk);
    rd_stb = 1'b0;
    // released address shows its inverse
    rd_addr = ~a;
    while (rd_valid !== 1'b1 && n < 4) begin
      @(negedge ref_clk);
      n++;
    end
    // no answer shows as unknown so the compare trips
    d = (rd_valid === 1'b1) ? rd_data : 16'hxxxx;
  endtask
endmodule
`default_nettype wire

//--- test/tb.sv
// self-checking bench for the status and identifier bank
// assumes the master model drives the read port
`include "phy_status_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module tb;
  import phy_status_pkg::*;
  localparam logic [23:0] ORG = 24'h0a1b2c;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  phy_events_type ev_in = '0;
  logic rd_stb, rd_valid;
  logic [7:0] rd_addr;
  logic [15:0] rd_data, got, zero_data;
  logic zero_valid;
  int err_total = 0, checks_done = 0, seed = 99;
  logic rf = 1'b0, jab = 1'b0, lnk = 1'b0;
  always #5 ref_clk = ~ref_clk;
  phy_status_and_ident_regs dut (.ref_clk(ref_clk), .arst_n(arst_n), .ev_in(ev_in), .rd_stb(rd_stb),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid));
  phy_status_and_ident_regs #(.IDENT_ZERO(1'b1)) dut_zero (.ref_clk(ref_clk), .arst_n(arst_n), .ev_in(ev_in),
    .rd_stb(rd_stb), .rd_addr(rd_addr), .rd_data(zero_data), .rd_valid(zero_valid));
  mgmt_master_model master (.ref_clk(ref_clk), .rd_valid(rd_valid), .rd_data(rd_data),
    .rd_stb(rd_stb), .rd_addr(rd_addr));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // status read, then latches reload from live conditions
  task automatic stat_read();
    master.rd(`OFS_BASIC_STATUS, got);
    chk("status", {9'h000, 1'b1, ev_in.aneg_done, rf, 1'b1, lnk, jab, 1'b1}, got);
    rf = ev_in.far_fault | ev_in.lp_fault;
    jab = ev_in.jabber & ev_in.speed_10;
    lnk = ev_in.link_good;
  endtask
  // ----------------
  // main sequence
  // ----------------
  initial begin
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    arst_n = 1'b1;
    stat_read();
    master.rd(`OFS_IDENT_HIGH, got);
    chk("ident_high", ORG[21:6], got);
    chk("ident_high_zero", 16'h0000, zero_data);
    master.rd(`OFS_IDENT_LOW, got);
    chk("ident_low", {ORG[5:0], 6'h01, 4'h0}, got);
    chk("ident_low_zero", 16'h0000, zero_data);
    master.rd(8'h90, got);
    chk("unmapped", 16'h0000, got);
    $display("test reset and identifier done");
    repeat (24) begin
      @(negedge ref_clk);
      ev_in = 6'($random(seed));
      repeat (6) @(negedge ref_clk);
      rf = rf | ev_in.far_fault | ev_in.lp_fault;
      jab = jab | (ev_in.jabber & ev_in.speed_10);
      lnk = lnk & ev_in.link_good;
      stat_read();
      stat_read();
    end
    $display("test random events done");
    give_verdict();
  end
  initial begin
    #100000;
    err_total++;
    give_verdict();
  end
endmodule
`default_nettype wire
